// *** design/psm_top.sv ***
`include "psm_defs.svh"
`default_nettype none
module psm_top #(
    parameter int unsigned HALF_SEC_CYCLES = `PSM_HALF_SEC_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic scan_tick,
    input wire logic program_start,
    input wire logic data_lost,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic [7:0] system_marker,
    output logic [7:0] coil_out,
    output logic irq
);
    psm_link_if lk();

    logic [22:0] half_cnt;
    logic half_tick;
    logic sec_clk;
    logic [5:0] slow_cnt;
    logic slow_clk;
    logic slow_edge;

    psm_pkg::psm_scan_e scan_state;
    logic init_pend;
    logic power_pend;
    logic cyc_phase;
    logic [2:0] lost_sync;
    logic lost_level;

    logic [31:0] var_addr_reg;
    psm_pkg::psm_size_e acc_size_reg;
    logic [2:0] bit_no_reg;
    logic chk_pend;
    logic [31:0] rung_cfg_reg;
    logic [15:0] box_cnt;

    logic [`PSM_EV_NUM-1:0] status_reg;
    logic [`PSM_EV_NUM-1:0] status_next;
    logic [`PSM_EV_NUM-1:0] irq_en_reg;
    logic [`PSM_EV_NUM-1:0] clr_mask;
    logic [`PSM_EV_NUM-1:0] events;

    logic [31:0] decoded;
    logic [2:0] coil_idx;

    // ==========================================
    // Sub blocks
    psm_addr_decode u_dec (
        .lk(lk.dec)
    );

    psm_rung_eval u_rung (
        .lk(lk.rung)
    );

    assign lk.var_addr = var_addr_reg;
    assign lk.acc_size = acc_size_reg;
    // Markers in the low byte, coils in the high byte
    assign lk.operands = {coil_out, system_marker};
    assign lk.rung_cfg = rung_cfg_reg;
    assign coil_idx = rung_cfg_reg[`PSM_COIL_IDX_LSB+2:`PSM_COIL_IDX_LSB];

    assign decoded = {2'b00, lk.align_ok, lk.addr_ok, lk.offset, lk.subarea,
        lk.range_no, lk.type_no};

    // ==========================================
    // Half-second time base
    assign half_tick = half_cnt == 23'(HALF_SEC_CYCLES - 1);

    always_ff @(posedge clock) begin
        if (rst) begin
            half_cnt <= 23'h00_0000;
        end else if (half_tick) begin
            half_cnt <= 23'h00_0000;
        end else begin
            half_cnt <= half_cnt + 23'h00_0001;
        end
    end

    // Starts low, flips every half second
    always_ff @(posedge clock) begin
        if (rst) begin
            sec_clk <= 1'b0;
        end else if (half_tick) begin
            sec_clk <= ~sec_clk;
        end
    end

    // ==========================================
    // Thirty-second half period
    assign slow_edge = half_tick && slow_cnt == 6'(`PSM_SLOW_TICKS - 1);

    always_ff @(posedge clock) begin
        if (rst) begin
            slow_cnt <= 6'h00;
        end else if (slow_edge) begin
            slow_cnt <= 6'h00;
        end else if (half_tick) begin
            slow_cnt <= slow_cnt + 6'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            slow_clk <= 1'b0;
        end else if (slow_edge) begin
            slow_clk <= ~slow_clk;
        end
    end

    // ==========================================
    // Scan sequencer
    always_ff @(posedge clock) begin
        if (rst) begin
            scan_state <= psm_pkg::PSM_IDLE;
        end else begin
            case (scan_state)
                psm_pkg::PSM_IDLE: begin
                    if (scan_tick) begin
                        scan_state <= psm_pkg::PSM_MARK;
                    end
                end
                psm_pkg::PSM_MARK: begin
                    scan_state <= psm_pkg::PSM_EVAL;
                end
                psm_pkg::PSM_EVAL: begin
                    scan_state <= psm_pkg::PSM_IDLE;
                end
                default: begin
                    scan_state <= psm_pkg::PSM_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // Data-lost pin synchroniser
    always_ff @(posedge clock) begin
        if (rst) begin
            lost_sync <= 3'h0;
        end else begin
            lost_sync <= {lost_sync[1:0], data_lost};
        end
    end

    // Level moves only once the last two stages agree
    always_ff @(posedge clock) begin
        if (rst) begin
            lost_level <= 1'b0;
        end else if (lost_sync[1] == lost_sync[2]) begin
            lost_level <= lost_sync[2];
        end
    end

    // ==========================================
    // First-scan flags
    // A start request in the marking cycle applies to the next scan
    always_ff @(posedge clock) begin
        if (rst) begin
            init_pend <= 1'b1;
        end else if (program_start) begin
            init_pend <= 1'b1;
        end else if (scan_state == psm_pkg::PSM_MARK) begin
            init_pend <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            power_pend <= 1'b1;
        end else if (scan_state == psm_pkg::PSM_MARK) begin
            power_pend <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cyc_phase <= 1'b0;
        end else if (scan_state == psm_pkg::PSM_MARK) begin
            cyc_phase <= ~cyc_phase;
        end
    end

    // ==========================================
    // Marker byte, written only by the sequencer
    always_ff @(posedge clock) begin
        if (rst) begin
            system_marker <= `PSM_MARKER_RST;
        end else if (scan_state == psm_pkg::PSM_MARK) begin
            system_marker[0] <= 1'b1;
            system_marker[1] <= init_pend;
            system_marker[2] <= power_pend & lost_level;
            system_marker[3] <= power_pend;
            system_marker[4] <= slow_clk;
            system_marker[5] <= sec_clk;
            system_marker[6] <= cyc_phase;
            system_marker[7] <= 1'b0;
        end
    end

    // ==========================================
    // Rung evaluation after markers settle
    always_ff @(posedge clock) begin
        if (rst) begin
            coil_out <= 8'h00;
        end else if (scan_state == psm_pkg::PSM_EVAL) begin
            coil_out[coil_idx] <= lk.rung_pass;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            box_cnt <= 16'h0000;
        end else if (scan_state == psm_pkg::PSM_EVAL && lk.box_fire) begin
            box_cnt <= box_cnt + 16'h0001;
        end
    end

    // ==========================================
    // Register writes
    always_ff @(posedge clock) begin
        if (rst) begin
            var_addr_reg <= `PSM_WORD_RST;
        end else if (reg_wr && reg_addr == `PSM_OFF_VAR_ADDR) begin
            var_addr_reg <= reg_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            acc_size_reg <= psm_pkg::PSM_SIZE_BIT;
            bit_no_reg <= 3'h0;
        end else if (reg_wr && reg_addr == `PSM_OFF_ACC_CFG) begin
            acc_size_reg <= psm_pkg::psm_size_e'(reg_wdata[1:0]);
            bit_no_reg <= reg_wdata[6:4];
        end
    end

    // Check one cycle after either address field changes
    always_ff @(posedge clock) begin
        if (rst) begin
            chk_pend <= 1'b0;
        end else begin
            chk_pend <= reg_wr && (reg_addr == `PSM_OFF_VAR_ADDR ||
                reg_addr == `PSM_OFF_ACC_CFG);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rung_cfg_reg <= `PSM_WORD_RST;
        end else if (reg_wr && reg_addr == `PSM_OFF_RUNG_CFG) begin
            rung_cfg_reg <= reg_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            irq_en_reg <= '0;
        end else if (reg_wr && reg_addr == `PSM_OFF_IRQ_EN) begin
            irq_en_reg <= reg_wdata[`PSM_EV_NUM-1:0];
        end
    end

    // ==========================================
    // Events and interrupt
    assign clr_mask = (reg_wr && reg_addr == `PSM_OFF_IRQ_CLR) ?
        reg_wdata[`PSM_EV_NUM-1:0] : '0;

    always_comb begin
        events = '0;
        events[`PSM_EV_SCAN] = scan_state == psm_pkg::PSM_MARK;
        events[`PSM_EV_FIRST] = scan_state == psm_pkg::PSM_MARK && power_pend;
        events[`PSM_EV_SEC] = half_tick & ~sec_clk;
        events[`PSM_EV_SLOW] = slow_edge & ~slow_clk;
        events[`PSM_EV_ADDR] = chk_pend & ~(lk.addr_ok & lk.align_ok);
        events[`PSM_EV_BOX] = scan_state == psm_pkg::PSM_EVAL && lk.box_fire;
    end

    // A new event beats a clear in the same cycle
    assign status_next = (status_reg & ~clr_mask) | events;

    always_ff @(posedge clock) begin
        if (rst) begin
            status_reg <= '0;
        end else begin
            status_reg <= status_next;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_next & irq_en_reg);
        end
    end

    // ==========================================
    // Register reads, data valid one cycle after the strobe only
    always_ff @(posedge clock) begin
        if (rst) begin
            reg_rdata <= `PSM_WORD_RST;
        end else if (!reg_rd) begin
            reg_rdata <= `PSM_WORD_RST;
        end else if (reg_addr == `PSM_OFF_MARKER) begin
            reg_rdata <= {24'h00_0000, system_marker};
        end else if (reg_addr == `PSM_OFF_STATUS) begin
            reg_rdata <= 32'(status_reg);
        end else if (reg_addr == `PSM_OFF_IRQ_EN) begin
            reg_rdata <= 32'(irq_en_reg);
        end else if (reg_addr == `PSM_OFF_VAR_ADDR) begin
            reg_rdata <= var_addr_reg;
        end else if (reg_addr == `PSM_OFF_ACC_CFG) begin
            reg_rdata <= {25'h000_0000, bit_no_reg, 2'b00, acc_size_reg};
        end else if (reg_addr == `PSM_OFF_DECODED) begin
            reg_rdata <= decoded;
        end else if (reg_addr == `PSM_OFF_RUNG_CFG) begin
            reg_rdata <= rung_cfg_reg;
        end else if (reg_addr == `PSM_OFF_COILS) begin
            reg_rdata <= {24'h00_0000, coil_out};
        end else if (reg_addr == `PSM_OFF_BOX_CNT) begin
            reg_rdata <= {16'h0000, box_cnt};
        end else begin
            reg_rdata <= `PSM_WORD_RST;
        end
    end
    // Writes to the marker offset fall through every decode above
endmodule // psm_top
`default_nettype wire

// *** include/psm_defs.svh ***
// Behaviour
// - Marker bit 0 always reads one.
// - Marker bit 1 is one in first scan after program start only.
// - Marker bit 2 flags buffered data lost, valid in first scan only.
// - Marker bit 3 is one in first scan after power on only.
// - Marker bit 4 is 60 s square wave: 30 s low, 30 s high.
// - Marker bit 5 is 1 s square wave: 0.5 s low, 0.5 s high.
// - Marker bit 6 toggles every scan: one scan low, one high.
// - Split eight-digit variable address into type, range, subarea, offset.
// - Function box runs only while its enable is active.
// - Contacts pass on operand one, or on operand zero when inverted.
// - Each coil is one stored bit written from its rung result.
`ifndef PSM_DEFS_SVH
`define PSM_DEFS_SVH

// ==========================================
// Register offsets
`define PSM_OFF_MARKER 8'h00
`define PSM_OFF_STATUS 8'h04
`define PSM_OFF_IRQ_EN 8'h08
`define PSM_OFF_IRQ_CLR 8'h0C
`define PSM_OFF_VAR_ADDR 8'h10
`define PSM_OFF_ACC_CFG 8'h14
`define PSM_OFF_DECODED 8'h18
`define PSM_OFF_RUNG_CFG 8'h1C
`define PSM_OFF_COILS 8'h20
`define PSM_OFF_BOX_CNT 8'h24

// ==========================================
// Reset values
`define PSM_MARKER_RST 8'h01
`define PSM_WORD_RST 32'h0000_0000

// ==========================================
// Status event bits
`define PSM_EV_SCAN 0
`define PSM_EV_FIRST 1
`define PSM_EV_SEC 2
`define PSM_EV_SLOW 3
`define PSM_EV_ADDR 4
`define PSM_EV_BOX 5
`define PSM_EV_NUM 6

// ==========================================
// Rung configuration fields
`define PSM_CONTACTS 4
`define PSM_CT_STRIDE 5
`define PSM_CT_USED_LSB 20
`define PSM_COIL_IDX_LSB 24
`define PSM_BOX_EN_BIT 27

// ==========================================
// Timing
`define PSM_CLK_HZ 10000000
`define PSM_HALF_SEC_MS 500
`define PSM_HALF_SEC_CYC (`PSM_HALF_SEC_MS * (`PSM_CLK_HZ / 1000))
`define PSM_SLOW_HALF_S 30
`define PSM_SLOW_TICKS (`PSM_SLOW_HALF_S * 1000 / `PSM_HALF_SEC_MS)

`endif

// *** include/psm_pkg.sv ***
`default_nettype none
package psm_pkg;
    typedef enum logic [1:0] {
        PSM_SIZE_BIT = 2'b00,
        PSM_SIZE_BYTE = 2'b01,
        PSM_SIZE_WORD = 2'b10,
        PSM_SIZE_DWORD = 2'b11
    } psm_size_e;

    typedef enum logic [1:0] {
        PSM_IDLE = 2'b00,
        PSM_MARK = 2'b01,
        PSM_EVAL = 2'b10
    } psm_scan_e;
endpackage
`default_nettype wire

// *** include/psm_link_if.sv ***
`default_nettype none
interface psm_link_if;
    logic [31:0] var_addr;
    psm_pkg::psm_size_e acc_size;
    logic [6:0] type_no;
    logic [6:0] range_no;
    logic [3:0] subarea;
    logic [9:0] offset;
    logic addr_ok;
    logic align_ok;
    logic [15:0] operands;
    logic [31:0] rung_cfg;
    logic rung_pass;
    logic box_fire;

    modport dec(input var_addr, input acc_size, output type_no, output range_no,
        output subarea, output offset, output addr_ok, output align_ok);
    modport rung(input operands, input rung_cfg, output rung_pass, output box_fire);
    modport top(output var_addr, output acc_size, output operands, output rung_cfg,
        input type_no, input range_no, input subarea, input offset, input addr_ok,
        input align_ok, input rung_pass, input box_fire);
endinterface
`default_nettype wire

// *** design/psm_addr_decode.sv ***
`default_nettype none
module psm_addr_decode (
    psm_link_if.dec lk
);
    logic [7:0] dig_ok;
    logic [6:0] lo2;

    function automatic logic [6:0] psm_bcd2(input logic [3:0] hi, input logic [3:0] lo);
        psm_bcd2 = 7'({3'b000, hi} * 7'd10 + {3'b000, lo});
    endfunction

    // ==========================================
    // Digit split
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_dig
            assign dig_ok[i] = lk.var_addr[4*i+3:4*i] <= 4'h9;
        end
    endgenerate

    assign lk.type_no = psm_bcd2(lk.var_addr[31:28], lk.var_addr[27:24]);
    assign lk.range_no = psm_bcd2(lk.var_addr[23:20], lk.var_addr[19:16]);
    assign lk.subarea = lk.var_addr[15:12];
    assign lk.offset = 10'({6'b00_0000, lk.var_addr[11:8]} * 10'd100) + {3'b000, lo2};
    assign lo2 = psm_bcd2(lk.var_addr[7:4], lk.var_addr[3:0]);
    assign lk.addr_ok = (&dig_ok) && lk.type_no >= 7'd10 && lk.type_no <= 7'd79;

    // Hundreds are multiples of four, so the low two digits decide
    always_comb begin
        case (lk.acc_size)
            psm_pkg::PSM_SIZE_WORD: lk.align_ok = ~lo2[0];
            psm_pkg::PSM_SIZE_DWORD: lk.align_ok = lo2[1:0] == 2'b00;
            default: lk.align_ok = 1'b1;
        endcase
    end
endmodule // psm_addr_decode
`default_nettype wire

// *** design/psm_rung_eval.sv ***
`include "psm_defs.svh"
`default_nettype none
module psm_rung_eval (
    psm_link_if.rung lk
);
    logic [`PSM_CONTACTS-1:0] pass;

    genvar i;
    generate
        for (i = 0; i < `PSM_CONTACTS; i++) begin : g_ct
            logic [3:0] sel;
            logic inv;
            logic used;
            assign sel = lk.rung_cfg[`PSM_CT_STRIDE*i+3:`PSM_CT_STRIDE*i];
            assign inv = lk.rung_cfg[`PSM_CT_STRIDE*i+4];
            assign used = lk.rung_cfg[`PSM_CT_USED_LSB+i];
            // Unused contact is a plain wire
            assign pass[i] = ~used | (inv ? ~lk.operands[sel] : lk.operands[sel]);
        end
    endgenerate

    assign lk.rung_pass = &pass;
    assign lk.box_fire = lk.rung_pass & lk.rung_cfg[`PSM_BOX_EN_BIT];
endmodule // psm_rung_eval
`default_nettype wire

// *** test/psm_top_sva.sv ***
`default_nettype none
module psm_top_sva #(
    parameter int unsigned HALF_SEC_CYCLES = 10
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic scan_tick,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_rdata,
    input wire logic [7:0] system_marker,
    input wire logic [7:0] coil_out
);
    logic [7:0] sm_q;
    logic pwr_seen;
    int sec_cnt;
    int slow_cnt;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    // ==========================================
    // Cycles since the second and slow clock markers last moved
    always_ff @(posedge clock) begin
        sm_q <= system_marker;
        pwr_seen <= !rst && (pwr_seen || system_marker[3]);
        sec_cnt <= (rst || sm_q[5] != system_marker[5]) ? 0 : sec_cnt + 1;
        slow_cnt <= (rst || sm_q[4] != system_marker[4]) ? 0 : slow_cnt + 1;
    end
    property p_one;
        system_marker[0];
    endproperty
    a_one: assert property (p_one) else $error("marker bit 0 low");
    property p_init;
        $rose(system_marker[3]) |-> system_marker[1];
    endproperty
    a_init: assert property (p_init) else $error("init flag missing");
    property p_lost;
        system_marker[2] |-> system_marker[3];
    endproperty
    a_lost: assert property (p_lost) else $error("lost flag after first scan");
    property p_pwr;
        $rose(system_marker[3]) |-> !pwr_seen;
    endproperty
    a_pwr: assert property (p_pwr) else $error("power flag raised twice");
    property p_slow;
        $changed(system_marker[4]) |-> slow_cnt > 50 * HALF_SEC_CYCLES;
    endproperty
    a_slow: assert property (p_slow) else $error("slow clock moved early");
    property p_sec;
        $changed(system_marker[5]) |-> sec_cnt > HALF_SEC_CYCLES / 2;
    endproperty
    a_sec: assert property (p_sec) else $error("second clock moved early");
    property p_tog;
        $fell(system_marker[3]) |-> $rose(system_marker[6]);
    endproperty
    a_tog: assert property (p_tog) else $error("cycle clock not toggled");
    property p_upd;
        $changed(system_marker) |-> $past(scan_tick) || $past(scan_tick, 2);
    endproperty
    a_upd: assert property (p_upd) else $error("marker moved outside scan");
    property p_coil;
        $changed(coil_out) |-> $past(scan_tick, 2) || $past(scan_tick, 3);
    endproperty
    a_coil: assert property (p_coil) else $error("coil moved outside scan");
    property p_rdm;
        $past(reg_rd) && $past(reg_addr) == 8'h00 |->
            reg_rdata == {24'h00_0000, $past(system_marker)};
    endproperty
    a_rdm: assert property (p_rdm) else $error("marker read wrong");
endmodule // psm_top_sva
bind psm_top psm_top_sva #(.HALF_SEC_CYCLES(HALF_SEC_CYCLES)) u_sva (.clock(clock), .rst(rst),
    .scan_tick(scan_tick), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .system_marker(system_marker), .coil_out(coil_out));
`default_nettype wire

// *** test/plc_system_marker_unit_tb_top.sv ***
`default_nettype none
module plc_system_marker_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int H = 10;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic scan_tick = 1'b0;
    logic program_start = 1'b0;
    logic data_lost = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [7:0] system_marker;
    logic [7:0] coil_out;
    logic irq;
    logic rd_seen = 1'b0;
    logic [63:0] exp_q[$];
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [31:0] seed = 32'h2e6b_fd41;
    logic first = 1'b1;
    logic armed = 1'b1;
    logic tog = 1'b0;
    logic [31:0] lm;
    logic [7:0] coils = 8'h00;
    logic [15:0] boxes = 16'h0000;
    logic [31:0] cfg;
    logic [31:0] d;
    logic [31:0] tbl [5] = '{32'h0010_0000, 32'h0010_0010, 32'h0030_02e0, 32'h0000_0000,
        32'h0020_00e0};
    logic [4:0] pass = 5'b01101;
    logic [31:0] av [7] = '{32'h3801_4001, 32'h1400_0002, 32'h1400_0002, 32'h7999_9994,
        32'h0999_9999, 32'h8000_0000, 32'h7999_9999};
    logic [1:0] sv [7] = '{2'h0, 2'h2, 2'h3, 2'h3, 2'h1, 2'h0, 2'h2};

    always #50 clock = ~clock;

    psm_top #(.HALF_SEC_CYCLES(H)) u_dut (.clock, .rst, .scan_tick, .program_start, .data_lost,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .system_marker, .coil_out, .irq);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] dec(input logic [31:0] a, input logic [1:0] s);
        int t;
        int o;
        logic ok;
        logic al;
        t = a[31:28] * 10 + a[27:24];
        o = a[11:8] * 100 + a[7:4] * 10 + a[3:0];
        ok = t >= 10 && t <= 79;
        al = s < 2 || (s == 2 && !a[0]) || (s == 3 && (a[7:4] * 10 + a[3:0]) % 4 == 0);
        return {2'b00, al, ok, 10'(o), a[15:12], 7'(a[23:20] * 10 + a[19:16]), 7'(t)};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        total_checks++;
        if ((got & m) !== (exp & m)) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got & m, exp & m);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // ==========================================
    // Register bus master
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back({m, e});
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
    endtask

    task automatic ck_irq(input logic e);
        repeat (3) @(posedge clock);
        chk({31'h0, irq}, {31'h0, e}, 32'h0000_0001);
    endtask

    // Tick placed two cycles into each half-second so clock markers are settled
    task automatic scan();
        while (cyc % 10 != 2) @(posedge clock);
        scan_tick <= 1'b1;
        lm = {24'h00_0000, 1'b0, tog, 1'(cyc / H % 2), 1'(cyc / (60 * H) % 2), first,
            first & data_lost, armed, 1'b1};
        @(posedge clock);
        scan_tick <= 1'b0;
        repeat (2) @(posedge clock);
        rd(8'h00, lm);
        first = 1'b0;
        armed = 1'b0;
        tog = ~tog;
    endtask

    // ==========================================
    // Read result checker and timeout
    always @(posedge clock) begin
        rd_seen <= reg_rd;
        cyc <= rst ? 0 : cyc + 1;
        if (cyc == 12000) begin
            n_fail++;
            report_and_stop();
        end
        if (rd_seen && exp_q.size() > 0) begin
            chk(reg_rdata, exp_q[0][31:0], exp_q[0][63:32]);
            void'(exp_q.pop_front());
        end
    end

    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(8'h00, 32'h0000_0001);
        rd(8'h24, 32'h0000_0000);
        rd(8'h30, 32'h0000_0000);
        scan();
        wr(8'h00, 32'hffff_ffff);
        rd(8'h00, lm);
        wr(8'h08, 32'h0000_0010);
        rd(8'h08, 32'h0000_0010);
        for (int i = 0; i < 7; i++) begin
            wr(8'h10, 32'h1400_0000);
            wr(8'h14, {30'h0, sv[i]});
            wr(8'h0c, 32'h0000_003f);
            wr(8'h10, av[i]);
            d = dec(av[i], sv[i]);
            ck_irq(!(d[28] && d[29]));
            rd(8'h18, d);
            rd(8'h04, {27'h0, !(d[28] && d[29]), 4'h0}, 32'h0000_0010);
        end
        wr(8'h08, 32'h0000_0000);
        ck_irq(1'b0);
        wr(8'h08, 32'h0000_0010);
        ck_irq(1'b1);
        wr(8'h0c, 32'h0000_0010);
        ck_irq(1'b0);
        rd(8'h0c, 32'h0000_0000);
        for (int i = 0; i < 120; i++) begin
            seed = lfsr(seed);
            data_lost <= seed[0];
            cfg = tbl[i % 5] | {4'h0, seed[1], seed[4:2], 24'h00_0000};
            wr(8'h1c, cfg);
            if (i == 30) begin
                program_start <= 1'b1;
                @(posedge clock);
                program_start <= 1'b0;
                armed = 1'b1;
            end
            repeat (seed[8:5]) @(posedge clock);
            scan();
            coils[seed[4:2]] = pass[i % 5];
            boxes += 16'(pass[i % 5] & seed[1]);
            rd(8'h20, {24'h00_0000, coils});
            rd(8'h24, {16'h0000, boxes}, 32'h0000_ffff);
        end
        rd(8'h1c, cfg);
        repeat (2) @(posedge clock);
        report_and_stop();
    end
endmodule // plc_system_marker_unit_tb_top
`default_nettype wire
